// [pmr_pkg.sv]
// pmr_pkg: constants for the transceiver management register bank
// assumes: registers sit on an apb word grid, byte address = index * 4
package pmr_pkg;
    // ----------------------------------------
    // register indices
    // ----------------------------------------
    localparam int unsigned APB_AW = 8;
    localparam logic [5:0] IDX_BSTAT = 6'h01;
    localparam logic [5:0] IDX_IDHI = 6'h02;
    localparam logic [5:0] IDX_IDLO = 6'h03;
    localparam logic [5:0] IDX_ADV = 6'h04;
    localparam logic [5:0] IDX_LPBP = 6'h05;
    localparam logic [5:0] IDX_EXP = 6'h06;
    localparam logic [5:0] IDX_NPTX = 6'h07;
    localparam logic [5:0] IDX_NPRX = 6'h08;
    localparam logic [5:0] IDX_GCTL = 6'h09;
    localparam logic [5:0] IDX_GSTS = 6'h0A;
    localparam logic [5:0] IDX_GEXT = 6'h0F;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int unsigned BS_JAB = 1;
    localparam int unsigned BS_LINK = 2;
    localparam int unsigned BS_RF = 4;
    localparam int unsigned BS_ANC = 5;
    localparam int unsigned EXP_PGRX = 1;
    localparam int unsigned EXP_PDF = 4;
    // ----------------------------------------
    // reset and fixed values
    // ----------------------------------------
    localparam logic [15:0] BSTAT_FIXED = 16'h7949;
    localparam logic [15:0] EXP_FIXED = 16'h0004;
    localparam logic [15:0] GEXT_VAL = 16'h3000;
    localparam logic [4:0] ADV_SEL = 5'h01;
    localparam logic [3:0] ADV_TECH_RST = 4'hF;
    localparam logic [10:0] NPT_MSG_RST = 11'h001;
    localparam logic NPT_MP_RST = 1'b1;
    localparam logic [7:0] GCTL_RST = 8'h00;
    // ----------------------------------------
    // test mode codes
    // ----------------------------------------
    localparam logic [2:0] TM_JITTER = 3'h1;
    localparam logic [2:0] TM_JIT_MST = 3'h2;
    localparam logic [2:0] TM_JIT_SLV = 3'h3;
    localparam logic [2:0] TM_DISTORT = 3'h4;
endpackage : pmr_pkg

// [pmr_regs.sv]
// pmr_regs: management register bank of the ethernet transceiver
// assumes: apb master on clk_sys; status inputs come from phy core logic on clk_sys
`timescale 1ns/1ps
`default_nettype none

module pmr_regs #(
    // arbitrary identifier values
    parameter logic [15:0] ORG_ID_HIGH = 16'h0A5A,
    parameter logic [15:0] ORG_ID_LOW = 16'h5A30
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pmr_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic linkUp,
    input wire logic jabber,
    input wire logic anComplete,
    input wire logic remoteFaultEvt,
    input wire logic [15:0] partnerBasePage,
    input wire logic [15:0] partnerNextPage,
    input wire logic pageRxEvt,
    input wire logic parallelFaultEvt,
    input wire logic partnerNpAble,
    input wire logic partnerAnAble,
    input wire logic npAck2,
    input wire logic npToggle,
    input wire logic msConfigFault,
    input wire logic msResolvedMaster,
    input wire logic localRxOk,
    input wire logic remoteRxOk,
    input wire logic partnerGigFull,
    input wire logic partnerGigHalf,
    input wire logic [7:0] idleErrMsb,
    output logic [15:0] advWord,
    output logic [15:0] nextPageWord,
    output logic testJitter,
    output logic testJitterMaster,
    output logic testJitterSlave,
    output logic testDistortion,
    output logic msForceMaster,
    output logic msForceSlave,
    output logic msPreferMaster,
    output logic advGigFull,
    output logic advGigHalf
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic advNp;
        logic advRf;
        logic advAsym;
        logic advPause;
        logic [3:0] advTech;
        logic nptNp;
        logic nptMp;
        logic [10:0] nptMsg;
        logic [7:0] gctl;
        logic linkLat;
        logic rfLat;
        logic pageLat;
        logic pdfLat;
        logic [31:0] rdata;
    } pmr_state_t;

    pmr_state_t state_ff;
    pmr_state_t nxt_state;
    logic [5:0] idx;
    logic setup;
    logic access;
    logic rdBs;
    logic rdEx;

    function automatic logic isMapped(input logic [5:0] i);
        isMapped = (i >= pmr_pkg::IDX_BSTAT && i <= pmr_pkg::IDX_GSTS)
            || i == pmr_pkg::IDX_GEXT;
    endfunction : isMapped

    // byte lanes 0 and 1 carry the 16-bit register, upper lanes are ignored
    function automatic logic [15:0] mergeLanes(input logic [15:0] old,
        input logic [15:0] wd, input logic [1:0] strb);
        mergeLanes = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
    endfunction : mergeLanes

    assign idx = paddr[7:2];
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign rdBs = access && !pwrite && idx == pmr_pkg::IDX_BSTAT;
    assign rdEx = access && !pwrite && idx == pmr_pkg::IDX_EXP;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [15:0] rw;
        logic [15:0] w;
        rw = 16'h0000;
        w = 16'h0000;
        nxt_state = state_ff;
        unique case (idx)
            pmr_pkg::IDX_BSTAT: begin
                rw = pmr_pkg::BSTAT_FIXED;
                rw[pmr_pkg::BS_LINK] = state_ff.linkLat;
                rw[pmr_pkg::BS_JAB] = jabber;
                rw[pmr_pkg::BS_RF] = state_ff.rfLat;
                rw[pmr_pkg::BS_ANC] = anComplete;
            end
            pmr_pkg::IDX_IDHI: rw = ORG_ID_HIGH;
            pmr_pkg::IDX_IDLO: rw = ORG_ID_LOW;
            pmr_pkg::IDX_ADV: rw = advWord;
            // partner words only mean something once negotiation is done
            pmr_pkg::IDX_LPBP: rw = anComplete ? partnerBasePage : 16'h0000;
            pmr_pkg::IDX_EXP: begin
                rw = pmr_pkg::EXP_FIXED;
                rw[pmr_pkg::EXP_PDF] = state_ff.pdfLat;
                rw[3] = partnerNpAble;
                rw[pmr_pkg::EXP_PGRX] = state_ff.pageLat;
                rw[0] = partnerAnAble;
            end
            pmr_pkg::IDX_NPTX: rw = nextPageWord;
            pmr_pkg::IDX_NPRX: rw = anComplete ? {1'b0, partnerNextPage[14:0]} : 16'h0000;
            pmr_pkg::IDX_GCTL: rw = {state_ff.gctl, 8'h00};
            pmr_pkg::IDX_GSTS: rw = {msConfigFault, msResolvedMaster,
                localRxOk, remoteRxOk,
                partnerGigFull, partnerGigHalf,
                2'b00, idleErrMsb};
            pmr_pkg::IDX_GEXT: rw = pmr_pkg::GEXT_VAL;
            default: rw = 16'h0000;
        endcase
        // read word is captured at the setup edge so prdata comes from a flop
        if (setup && !pwrite) begin
            nxt_state.rdata = {16'h0000, rw};
        end
        // writes land at the access edge; read-only indices simply drop them
        if (access && pwrite) begin
            unique case (idx)
                pmr_pkg::IDX_ADV: begin
                    w = mergeLanes(advWord, pwdata[15:0], pstrb[1:0]);
                    nxt_state.advNp = w[15];
                    nxt_state.advRf = w[13];
                    nxt_state.advAsym = w[11];
                    nxt_state.advPause = w[10];
                    nxt_state.advTech = w[8:5];
                end
                pmr_pkg::IDX_NPTX: begin
                    w = mergeLanes(nextPageWord, pwdata[15:0], pstrb[1:0]);
                    nxt_state.nptNp = w[15];
                    nxt_state.nptMp = w[13];
                    nxt_state.nptMsg = w[10:0];
                end
                pmr_pkg::IDX_GCTL: begin
                    w = mergeLanes({state_ff.gctl, 8'h00}, pwdata[15:0], pstrb[1:0]);
                    nxt_state.gctl = w[15:8];
                end
                default: nxt_state.gctl = state_ff.gctl;
            endcase
        end
        // a read clears only what it showed, so an event after capture survives
        nxt_state.linkLat = linkUp
            && (state_ff.linkLat || (rdBs && !state_ff.rdata[pmr_pkg::BS_LINK]));
        nxt_state.rfLat = remoteFaultEvt
            || (state_ff.rfLat && !(rdBs && state_ff.rdata[pmr_pkg::BS_RF]));
        nxt_state.pageLat = pageRxEvt
            || (state_ff.pageLat && !(rdEx && state_ff.rdata[pmr_pkg::EXP_PGRX]));
        nxt_state.pdfLat = parallelFaultEvt
            || (state_ff.pdfLat && !(rdEx && state_ff.rdata[pmr_pkg::EXP_PDF]));
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_ff <= '{advNp: 1'b0, advRf: 1'b0, advAsym: 1'b0, advPause: 1'b0,
                advTech: pmr_pkg::ADV_TECH_RST, nptNp: 1'b0, nptMp: pmr_pkg::NPT_MP_RST,
                nptMsg: pmr_pkg::NPT_MSG_RST, gctl: pmr_pkg::GCTL_RST, linkLat: 1'b0,
                rfLat: 1'b0, pageLat: 1'b0, pdfLat: 1'b0, rdata: 32'h0000_0000};
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // zero wait states: the answer is always ready in the access phase
    assign pready = access;
    assign pslverr = access && !isMapped(idx);
    assign prdata = state_ff.rdata;
    assign advWord = {state_ff.advNp, 1'b0, state_ff.advRf, 1'b0, state_ff.advAsym,
        state_ff.advPause, 1'b0, state_ff.advTech, pmr_pkg::ADV_SEL};
    assign nextPageWord = {state_ff.nptNp, 1'b0, state_ff.nptMp, npAck2, npToggle,
        state_ff.nptMsg};
    // reserved codes 5 to 7 leave every test output low
    assign testJitter = state_ff.gctl[7:5] == pmr_pkg::TM_JITTER;
    assign testJitterMaster = state_ff.gctl[7:5] == pmr_pkg::TM_JIT_MST;
    assign testJitterSlave = state_ff.gctl[7:5] == pmr_pkg::TM_JIT_SLV;
    assign testDistortion = state_ff.gctl[7:5] == pmr_pkg::TM_DISTORT;
    assign msForceMaster = state_ff.gctl[4] && state_ff.gctl[3];
    assign msForceSlave = state_ff.gctl[4] && !state_ff.gctl[3];
    assign msPreferMaster = !state_ff.gctl[4] && state_ff.gctl[2];
    assign advGigFull = state_ff.gctl[1];
    assign advGigHalf = state_ff.gctl[0];

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // leaving the held-low state takes a read that showed the zero
    link_latch_a: assert property ((!linkUp || (!state_ff.linkLat && !rdBs))
        |=> !state_ff.linkLat)
        else $error("link status not held low after loss");
    jabber_rd_a: assert property (setup && !pwrite && idx == pmr_pkg::IDX_BSTAT
        |=> prdata[pmr_pkg::BS_JAB] == $past(jabber) && prdata[0])
        else $error("basic status read word wrong");
    rf_hold_a: assert property ((remoteFaultEvt || (state_ff.rfLat && !rdBs))
        |=> state_ff.rfLat)
        else $error("remote fault not latched");
    adv_fixed_a: assert property (advWord[4:0] == pmr_pkg::ADV_SEL
        && !advWord[9] && !advWord[14])
        else $error("advertisement fixed fields wrong");
    page_set_a: assert property (pageRxEvt |=> state_ff.pageLat)
        else $error("page received not latched");
    ms_manual_a: assert property (access && pwrite && idx == pmr_pkg::IDX_GCTL && pstrb[1]
        |=> msForceMaster == ($past(pwdata[12]) && $past(pwdata[11])))
        else $error("manual master select wrong");
    test_rsvd_a: assert property (state_ff.gctl[7:5] > pmr_pkg::TM_DISTORT
        |-> !(testJitter || testJitterMaster || testJitterSlave || testDistortion))
        else $error("reserved test code active");
    unmapped_a: assert property (access && !isMapped(idx) |-> pslverr && pready)
        else $error("unmapped access not refused");

    // ----------------------------------------
    // read word checks
    // ----------------------------------------
    // each read is judged one cycle after its setup edge, against what stood at that edge
    bstat_word_a: assert property (setup && !pwrite && idx == pmr_pkg::IDX_BSTAT
        |=> prdata[pmr_pkg::BS_ANC] == $past(anComplete)
        && prdata[pmr_pkg::BS_LINK] == $past(state_ff.linkLat)
        && prdata[pmr_pkg::BS_RF] == $past(state_ff.rfLat) && prdata[31:16] == 16'h0000)
        else $error("basic status latches shown wrong");
    id_words_a: assert property (setup && !pwrite
        && (idx == pmr_pkg::IDX_IDHI || idx == pmr_pkg::IDX_IDLO)
        |=> prdata[15:0] == ($past(idx) == pmr_pkg::IDX_IDLO ? ORG_ID_LOW : ORG_ID_HIGH))
        else $error("identifier word wrong");
    lpbp_gate_a: assert property (setup && !pwrite && idx == pmr_pkg::IDX_LPBP
        |=> prdata[15:0] == ($past(anComplete) ? $past(partnerBasePage) : 16'h0000))
        else $error("partner base page word wrong");
    exp_rsvd_a: assert property (setup && !pwrite && idx == pmr_pkg::IDX_EXP
        |=> prdata[31:5] == 27'h000_0000 && prdata[2])
        else $error("expansion fixed bits wrong");
    nprx_word_a: assert property (setup && !pwrite && idx == pmr_pkg::IDX_NPRX
        && anComplete |=> prdata[15:0] == ($past(partnerNextPage) & 16'h7FFF))
        else $error("next page receive word wrong");
    gsts_map_a: assert property (setup && !pwrite && idx == pmr_pkg::IDX_GSTS
        |=> prdata[15] == $past(msConfigFault) && prdata[14] == $past(msResolvedMaster)
        && prdata[13] == $past(localRxOk) && prdata[12] == $past(remoteRxOk)
        && prdata[11] == $past(partnerGigFull) && prdata[10] == $past(partnerGigHalf)
        && prdata[9:8] == 2'b00 && prdata[7:0] == $past(idleErrMsb))
        else $error("gigabit status word wrong");
    gext_val_a: assert property (setup && !pwrite && idx == pmr_pkg::IDX_GEXT
        |=> prdata == {16'h0000, pmr_pkg::GEXT_VAL})
        else $error("extended status word wrong");
    unmapped_rd_a: assert property (setup && !pwrite && !isMapped(idx)
        |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    // ----------------------------------------
    // write and latch checks
    // ----------------------------------------
    // advertisement and next-page checks judge only full-word writes, gigabit control checks need only lane 1; the bench never drives partial strobes
    adv_write_a: assert property (access && pwrite && idx == pmr_pkg::IDX_ADV
        && pstrb[1:0] == 2'b11 |=> advWord[15:10] == ($past(pwdata[15:10]) & 6'h2B)
        && advWord[8:5] == $past(pwdata[8:5]))
        else $error("advertisement write lost");
    npt_write_a: assert property (access && pwrite && idx == pmr_pkg::IDX_NPTX
        && pstrb[1:0] == 2'b11 |=> nextPageWord[15] == $past(pwdata[15])
        && nextPageWord[13] == $past(pwdata[13]) && nextPageWord[10:0] == $past(pwdata[10:0]))
        else $error("next page transmit write lost");
    gig_adv_a: assert property (access && pwrite && idx == pmr_pkg::IDX_GCTL
        && pstrb[1] |=> advGigFull == $past(pwdata[9]) && advGigHalf == $past(pwdata[8]))
        else $error("gigabit advertise bits wrong");
    test_mode_a: assert property (access && pwrite && idx == pmr_pkg::IDX_GCTL
        && pstrb[1] |=> testDistortion == ($past(pwdata[15:13]) == pmr_pkg::TM_DISTORT)
        && testJitter == ($past(pwdata[15:13]) == pmr_pkg::TM_JITTER))
        else $error("test mode decode wrong");
    ms_auto_a: assert property (access && pwrite && idx == pmr_pkg::IDX_GCTL
        && pstrb[1] && !pwdata[12] |=> !msForceMaster && !msForceSlave
        && msPreferMaster == $past(pwdata[10]))
        else $error("automatic master preference wrong");
    ro_write_a: assert property (access && pwrite && idx != pmr_pkg::IDX_ADV
        && idx != pmr_pkg::IDX_NPTX && idx != pmr_pkg::IDX_GCTL
        |=> $stable(advWord) && $stable(state_ff.gctl) && $stable(state_ff.nptMsg))
        else $error("read-only write changed state");
    pdf_set_a: assert property (parallelFaultEvt |=> state_ff.pdfLat)
        else $error("parallel detection fault not latched");
    page_clear_a: assert property (rdEx && state_ff.rdata[pmr_pkg::EXP_PGRX]
        && !pageRxEvt |=> !state_ff.pageLat)
        else $error("page received not cleared by read");
    rf_clear_a: assert property (rdBs && state_ff.rdata[pmr_pkg::BS_RF]
        && !remoteFaultEvt |=> !state_ff.rfLat)
        else $error("remote fault not cleared by read");

    // ----------------------------------------
    // scenario covers
    // ----------------------------------------
    bs_read_c: cover property (setup && !pwrite && idx == pmr_pkg::IDX_BSTAT ##1 rdBs);
    adv_write_c: cover property (access && pwrite && idx == pmr_pkg::IDX_ADV);
    clear_race_c: cover property (rdBs && remoteFaultEvt);
    unmapped_c: cover property (pslverr);
    page_clear_c: cover property (rdEx && state_ff.rdata[pmr_pkg::EXP_PGRX]);
endmodule : pmr_regs

`default_nettype wire

// [pmr_mgmt_master.sv]
// pmr_mgmt_master: apb master standing in for the mac station management logic
// assumes: one clk_sys domain; the slave may add up to 15 wait states
`timescale 1ns/1ps
`default_nettype none
module pmr_mgmt_master (
    input wire logic clk_sys,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [pmr_pkg::APB_AW-1:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end
    // ----------------------------------------
    // one transfer: setup, then access until pready
    // ----------------------------------------
    task automatic xfer(input logic wr, input logic [5:0] idx, input logic [15:0] wd,
            output logic [31:0] rd, output logic err, output logic tmo);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, wd};
        pstrb <= 4'h3;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        tmo = (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released address and data lines flip so a stale value never passes for a driven one
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask : xfer
endmodule : pmr_mgmt_master
`default_nettype wire

// [pmr_regs_tb.sv]
// pmr_regs_tb: self-checking bench for the management register bank
// assumes: pmr_pkg, pmr_regs and pmr_mgmt_master are compiled first
`timescale 1ns/1ps
`default_nettype none
module pmr_regs_tb;
    // arbitrary identifier values
    localparam logic [15:0] ID_HI = 16'h1357;
    localparam logic [15:0] ID_LO = 16'h2468;
    localparam logic [5:0] RIX [11] = '{pmr_pkg::IDX_BSTAT, pmr_pkg::IDX_IDHI,
        pmr_pkg::IDX_IDLO, pmr_pkg::IDX_ADV, pmr_pkg::IDX_LPBP, pmr_pkg::IDX_EXP,
        pmr_pkg::IDX_NPTX, pmr_pkg::IDX_NPRX, pmr_pkg::IDX_GCTL, pmr_pkg::IDX_GSTS,
        pmr_pkg::IDX_GEXT};
    localparam logic [15:0] REXP [11] = '{16'h7949, ID_HI, ID_LO, 16'h01E1, 16'h0000,
        16'h0004, 16'h2001, 16'h0000, 16'h0000, 16'h0000, 16'h3000};
    localparam logic [5:0] BAD [5] = '{6'h00, 6'h0B, 6'h0E, 6'h10, 6'h3F};
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, errv, tmov;
    logic [7:0] paddr, idleErrMsb;
    logic [31:0] pwdata, prdata, rdv;
    logic [3:0] pstrb;
    logic linkUp, jabber, anComplete, remoteFaultEvt, pageRxEvt, parallelFaultEvt;
    logic partnerNpAble, partnerAnAble, npAck2, npToggle, msConfigFault, msResolvedMaster;
    logic localRxOk, remoteRxOk, partnerGigFull, partnerGigHalf;
    logic [15:0] partnerBasePage, partnerNextPage, advWord, nextPageWord;
    logic testJitter, testJitterMaster, testJitterSlave, testDistortion;
    logic msForceMaster, msForceSlave, msPreferMaster, advGigFull, advGigHalf;
    int mismatches = 0;
    int samples_checked = 0;
    always #2 clk_sys = ~clk_sys;
    pmr_mgmt_master u_pmr_mgmt_master (.clk_sys(clk_sys), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr));
    pmr_regs #(.ORG_ID_HIGH(ID_HI), .ORG_ID_LOW(ID_LO)) u_pmr_regs (.clk_sys(clk_sys),
        .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .linkUp(linkUp), .jabber(jabber), .anComplete(anComplete),
        .remoteFaultEvt(remoteFaultEvt), .partnerBasePage(partnerBasePage),
        .partnerNextPage(partnerNextPage), .pageRxEvt(pageRxEvt),
        .parallelFaultEvt(parallelFaultEvt), .partnerNpAble(partnerNpAble),
        .partnerAnAble(partnerAnAble), .npAck2(npAck2), .npToggle(npToggle),
        .msConfigFault(msConfigFault), .msResolvedMaster(msResolvedMaster),
        .localRxOk(localRxOk), .remoteRxOk(remoteRxOk), .partnerGigFull(partnerGigFull),
        .partnerGigHalf(partnerGigHalf), .idleErrMsb(idleErrMsb), .advWord(advWord),
        .nextPageWord(nextPageWord), .testJitter(testJitter),
        .testJitterMaster(testJitterMaster), .testJitterSlave(testJitterSlave),
        .testDistortion(testDistortion), .msForceMaster(msForceMaster),
        .msForceSlave(msForceSlave), .msPreferMaster(msPreferMaster),
        .advGigFull(advGigFull), .advGigHalf(advGigHalf));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic wr, input logic [5:0] idx, input logic [15:0] wd);
        u_pmr_mgmt_master.xfer(wr, idx, wd, rdv, errv, tmov);
        if (tmov !== 1'b0) begin
            mismatches++;
            wrap_up();
        end
    endtask : acc
    task automatic rchk(input logic [5:0] idx, input logic [15:0] exp, input logic eerr);
        acc(1'b0, idx, 16'h0000);
        chk(rdv, {16'h0000, exp});
        chk(32'(errv), 32'(eerr));
    endtask : rchk
    task automatic tick();
        @(posedge clk_sys);
    endtask : tick
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_status();
        tick();
        {linkUp, jabber, anComplete} <= 3'b111;
        rchk(pmr_pkg::IDX_BSTAT, 16'h796B, 1'b0);
        rchk(pmr_pkg::IDX_BSTAT, 16'h796F, 1'b0);
        tick();
        {linkUp, remoteFaultEvt} <= 2'b01;
        tick();
        {linkUp, remoteFaultEvt, jabber} <= 3'b100;
        rchk(pmr_pkg::IDX_BSTAT, 16'h7979, 1'b0);
        rchk(pmr_pkg::IDX_BSTAT, 16'h796D, 1'b0);
        $display("test status bits done");
    endtask : t_status
    task automatic t_adv();
        acc(1'b1, pmr_pkg::IDX_ADV, 16'hFFFF);
        rchk(pmr_pkg::IDX_ADV, 16'hADE1, 1'b0);
        chk(32'(advWord), 32'h0000_ADE1);
        acc(1'b1, pmr_pkg::IDX_ADV, 16'h0000);
        rchk(pmr_pkg::IDX_ADV, 16'h0001, 1'b0);
        $display("test advertisement done");
    endtask : t_adv
    task automatic t_pages();
        tick();
        anComplete <= 1'b0;
        partnerBasePage <= 16'hA5C3;
        partnerNextPage <= 16'hFFFF;
        rchk(pmr_pkg::IDX_LPBP, 16'h0000, 1'b0);
        tick();
        {anComplete, pageRxEvt, parallelFaultEvt, partnerNpAble, partnerAnAble} <= 5'h1F;
        tick();
        {pageRxEvt, parallelFaultEvt} <= 2'b00;
        acc(1'b1, pmr_pkg::IDX_LPBP, 16'h0000);
        rchk(pmr_pkg::IDX_LPBP, 16'hA5C3, 1'b0);
        rchk(pmr_pkg::IDX_NPRX, 16'h7FFF, 1'b0);
        rchk(pmr_pkg::IDX_EXP, 16'h001F, 1'b0);
        rchk(pmr_pkg::IDX_EXP, 16'h000D, 1'b0);
        tick();
        {npAck2, npToggle} <= 2'b11;
        acc(1'b1, pmr_pkg::IDX_NPTX, 16'hFFFF);
        rchk(pmr_pkg::IDX_NPTX, 16'hBFFF, 1'b0);
        chk(32'(nextPageWord), 32'h0000_BFFF);
        acc(1'b1, pmr_pkg::IDX_NPTX, 16'h0000);
        rchk(pmr_pkg::IDX_NPTX, 16'h1800, 1'b0);
        $display("test pages done");
    endtask : t_pages
    task automatic t_gig();
        logic [2:0] c;
        logic [15:0] w;
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            w = {c, c ^ 3'h5, c[1:0], 8'hFF};
            acc(1'b1, pmr_pkg::IDX_GCTL, w);
            rchk(pmr_pkg::IDX_GCTL, {w[15:8], 8'h00}, 1'b0);
            chk(32'({testJitter, testJitterMaster, testJitterSlave, testDistortion}),
                32'({c == 3'h1, c == 3'h2, c == 3'h3, c == 3'h4}));
            chk(32'({msForceMaster, msForceSlave, msPreferMaster}),
                32'({w[12] & w[11], w[12] & ~w[11], ~w[12] & w[10]}));
            chk(32'({advGigFull, advGigHalf}), 32'(w[9:8]));
        end
        tick();
        {msConfigFault, msResolvedMaster, localRxOk, remoteRxOk} <= 4'hA;
        {partnerGigFull, partnerGigHalf, idleErrMsb} <= 10'h2A5;
        rchk(pmr_pkg::IDX_GSTS, 16'hA8A5, 1'b0);
        tick();
        {msConfigFault, msResolvedMaster, localRxOk, remoteRxOk} <= 4'h5;
        {partnerGigFull, partnerGigHalf, idleErrMsb} <= 10'h15A;
        rchk(pmr_pkg::IDX_GSTS, 16'h545A, 1'b0);
        $display("test gigabit control and status done");
    endtask : t_gig
    task automatic t_bad();
        for (int i = 0; i < 5; i++) begin
            acc(1'b1, BAD[i], 16'hFFFF);
            rchk(BAD[i], 16'h0000, 1'b1);
        end
        acc(1'b1, pmr_pkg::IDX_GEXT, 16'h0000);
        rchk(pmr_pkg::IDX_GEXT, 16'h3000, 1'b0);
        $display("test unmapped and read-only done");
    endtask : t_bad
    task automatic t_defaults();
        for (int i = 0; i < 11; i++) begin
            rchk(RIX[i], REXP[i], 1'b0);
        end
        $display("test reset values done");
    endtask : t_defaults
    task automatic t_reset();
        acc(1'b1, pmr_pkg::IDX_ADV, 16'h0000);
        acc(1'b1, pmr_pkg::IDX_GCTL, 16'hFF00);
        tick();
        reset <= 1'b1;
        repeat (2) tick();
        chk(32'({advWord, advGigFull, testDistortion}), 32'h0000_0784);
        reset <= 1'b0;
        rchk(pmr_pkg::IDX_ADV, 16'h01E1, 1'b0);
        rchk(pmr_pkg::IDX_GCTL, 16'h0000, 1'b0);
        $display("test mid-run reset done");
    endtask : t_reset
    initial begin
        {linkUp, jabber, anComplete, remoteFaultEvt, pageRxEvt, parallelFaultEvt,
            partnerNpAble, partnerAnAble, npAck2, npToggle, msConfigFault, msResolvedMaster,
            localRxOk, remoteRxOk, partnerGigFull, partnerGigHalf, partnerBasePage,
            partnerNextPage, idleErrMsb} = '0;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        t_defaults();
        t_status();
        t_adv();
        t_pages();
        t_gig();
        t_bad();
        t_reset();
        wrap_up();
    end
endmodule : pmr_regs_tb
`default_nettype wire
